/* File: rtl/omb_cfg.svh */
// constants for the operating mode and boot control block
`ifndef OMB_CFG_SVH
`define OMB_CFG_SVH

`define OMB_CLK_HZ 100000000
`define OMB_CLK_MHZ 100
`define OMB_SETTLE_NS 160
`define OMB_SETTLE_CYC ((`OMB_SETTLE_NS * `OMB_CLK_MHZ + 999) / 1000)
`define OMB_ALERT_LEAD_NS 40
`define OMB_ALERT_LEAD_CYC ((`OMB_ALERT_LEAD_NS * `OMB_CLK_MHZ + 999) / 1000)
`define OMB_LS_CLK_HZ 32768
`define OMB_LS_TICK_CYC (`OMB_CLK_HZ / `OMB_LS_CLK_HZ)
`define OMB_MAX_BAUD 460000
`define OMB_MIN_BIT_CYC (`OMB_CLK_HZ / `OMB_MAX_BAUD)
`define OMB_SN_ADDR_LO 32'h100007F4
`define OMB_SN_ADDR_HI 32'h100007F8
`define OMB_SN_PAD 16'hAA55
`define OMB_WORD_ZERO 32'h00000000

`endif

/* File: rtl/omb_pkg.sv */
// types shared by the operating mode and boot control block
package omb_pkg;
	typedef enum logic [2:0] {
		omb_st_reset = 3'h0,
		omb_st_wake = 3'h1,
		omb_st_active = 3'h3,
		omb_st_lead = 3'h2,
		omb_st_radio = 3'h6,
		omb_st_sleep = 3'h7
	} omb_state_type;

	typedef struct packed {
		logic reg_en;
		logic hs_osc_en;
		logic ls_osc_en;
		logic rf_if_en;
		logic core_run;
		logic ram_retain;
		logic debug_pwr;
		logic trx_en;
		logic trx_tx;
	} omb_power_type;

	typedef struct packed {
		logic tx;
		logic rx;
	} omb_radio_req_type;
endpackage : omb_pkg

/* File: rtl/omb_top.sv */
// operating mode sequencer, boot selection, radio alert, serial number and baud detection
`timescale 1ns/1ps
`include "omb_cfg.svh"
module omb_top #(
	parameter logic [47:0] SERIAL_ID = 48'h0123456789AB // arbitrary value
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic external_reset_pin_n,
	input wire logic boot_strap_input,
	input wire logic sleep_req,
	input wire logic [15:0] wake_interval,
	input wire omb_pkg::omb_radio_req_type radio_req,
	input wire logic radio_done,
	input wire logic uart_rx_line,
	input wire logic sn_rd,
	input wire logic [31:0] sn_addr,
	output omb_pkg::omb_power_type power,
	output logic radio_activity_alert,
	output logic boot_from_rom,
	output logic boot_valid,
	output logic [31:0] sn_data,
	output logic [15:0] baud_div,
	output logic baud_locked
);
	omb_pkg::omb_state_type state;
	omb_pkg::omb_state_type next_state;
	logic [7:0] step_cnt;
	logic [11:0] ls_div;
	logic ls_tick;
	logic [15:0] wake_cnt;
	logic tx_mode;
	logic next_tx_mode;
	logic [15:0] low_cnt;

	function automatic omb_pkg::omb_power_type omb_power_of(input omb_pkg::omb_state_type st, input logic tx);
		omb_pkg::omb_power_type p;
		p = '0;
		unique case (st)
			omb_pkg::omb_st_reset: p = '0;
			omb_pkg::omb_st_sleep: begin
				// regulator stays up only to keep ram and state alive
				p.reg_en = 1'b1;
				p.ls_osc_en = 1'b1;
				p.ram_retain = 1'b1;
			end
			omb_pkg::omb_st_wake: begin
				p.reg_en = 1'b1;
				p.ls_osc_en = 1'b1;
				p.hs_osc_en = 1'b1;
				p.ram_retain = 1'b1;
			end
			default: begin
				p.reg_en = 1'b1;
				p.hs_osc_en = 1'b1;
				p.ls_osc_en = 1'b1;
				p.rf_if_en = 1'b1;
				p.core_run = 1'b1;
				p.ram_retain = 1'b1;
				p.debug_pwr = 1'b1;
				p.trx_en = (st == omb_pkg::omb_st_radio);
				p.trx_tx = (st == omb_pkg::omb_st_radio) && tx;
			end
		endcase
		return p;
	endfunction : omb_power_of

	// external reset outranks every mode, sampled as a synchronous level
	always_comb begin
		next_state = state;
		if (!external_reset_pin_n) begin
			next_state = omb_pkg::omb_st_reset;
		end else begin
			unique case (state)
				omb_pkg::omb_st_reset: next_state = omb_pkg::omb_st_wake;
				omb_pkg::omb_st_wake: begin
					if (step_cnt == 8'h00) begin
						next_state = omb_pkg::omb_st_active;
					end
				end
				omb_pkg::omb_st_active: begin
					// radio work wins over a sleep request
					if (radio_req.tx || radio_req.rx) begin
						next_state = omb_pkg::omb_st_lead;
					end else if (sleep_req) begin
						next_state = omb_pkg::omb_st_sleep;
					end
				end
				omb_pkg::omb_st_lead: begin
					if (step_cnt == 8'h00) begin
						next_state = omb_pkg::omb_st_radio;
					end
				end
				omb_pkg::omb_st_radio: begin
					if (radio_done) begin
						next_state = omb_pkg::omb_st_active;
					end
				end
				omb_pkg::omb_st_sleep: begin
					if (ls_tick && wake_cnt == 16'h0000) begin
						next_state = omb_pkg::omb_st_active;
					end
				end
				default: next_state = omb_pkg::omb_st_reset;
			endcase
		end
	end

	always_comb begin
		next_tx_mode = tx_mode;
		if (state == omb_pkg::omb_st_active) begin
			next_tx_mode = radio_req.tx; // transmit wins if both are asked
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= omb_pkg::omb_st_reset;
			tx_mode <= 1'b0;
		end else begin
			state <= next_state;
			tx_mode <= next_tx_mode;
		end
	end

	// outputs follow the next state so they line up with the state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power <= '0;
			radio_activity_alert <= 1'b0;
		end else begin
			power <= omb_power_of(next_state, next_tx_mode);
			radio_activity_alert <= (next_state == omb_pkg::omb_st_lead) ||
				(next_state == omb_pkg::omb_st_radio);
		end
	end

	// one counter times both the activation settle and the alert lead
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			step_cnt <= 8'h00;
		end else if (next_state == omb_pkg::omb_st_wake && state != omb_pkg::omb_st_wake) begin
			step_cnt <= 8'(`OMB_SETTLE_CYC - 1);
		end else if (next_state == omb_pkg::omb_st_lead && state != omb_pkg::omb_st_lead) begin
			step_cnt <= 8'(`OMB_ALERT_LEAD_CYC - 1);
		end else if (step_cnt != 8'h00) begin
			step_cnt <= step_cnt - 8'h01;
		end
	end

	// low-speed tick only runs in sleep, though the slow oscillator it stands for is enabled in every mode but reset
	assign ls_tick = (state == omb_pkg::omb_st_sleep) && (ls_div == 12'(`OMB_LS_TICK_CYC - 1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ls_div <= 12'h000;
		end else if (state != omb_pkg::omb_st_sleep || ls_tick) begin
			ls_div <= 12'h000;
		end else begin
			ls_div <= ls_div + 12'h001;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wake_cnt <= 16'h0000;
		end else if (next_state == omb_pkg::omb_st_sleep && state != omb_pkg::omb_st_sleep) begin
			wake_cnt <= wake_interval;
		end else if (ls_tick && wake_cnt != 16'h0000) begin
			wake_cnt <= wake_cnt - 16'h0001;
		end
	end

	// strap is caught on the first clock after any reset, never by the async reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_from_rom <= 1'b0;
			boot_valid <= 1'b0;
		end else if (!external_reset_pin_n) begin
			boot_valid <= 1'b0;
		end else if (state == omb_pkg::omb_st_reset) begin
			boot_from_rom <= boot_strap_input;
			boot_valid <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sn_data <= `OMB_WORD_ZERO;
		end else if (sn_rd) begin
			if (sn_addr == `OMB_SN_ADDR_LO) begin
				sn_data <= SERIAL_ID[31:0];
			end else if (sn_addr == `OMB_SN_ADDR_HI) begin
				sn_data <= {`OMB_SN_PAD, SERIAL_ID[47:32]};
			end else begin
				sn_data <= `OMB_WORD_ZERO;
			end
		end
	end

	// start bit width gives the bit time; narrower than the fastest rate is a glitch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_cnt <= 16'h0000;
			baud_div <= 16'h0000;
			baud_locked <= 1'b0;
		end else if (state == omb_pkg::omb_st_reset) begin
			low_cnt <= 16'h0000;
			baud_div <= 16'h0000;
			baud_locked <= 1'b0;
		end else if (boot_valid && boot_from_rom && !baud_locked) begin
			if (!uart_rx_line) begin
				if (low_cnt != 16'hFFFF) begin
					low_cnt <= low_cnt + 16'h0001;
				end
			end else begin
				if (low_cnt >= 16'(`OMB_MIN_BIT_CYC)) begin
					baud_div <= low_cnt;
					baud_locked <= 1'b1;
				end
				low_cnt <= 16'h0000;
			end
		end
	end

	localparam int wake_lim = `OMB_SETTLE_CYC + 1;
	localparam int lead_cyc = `OMB_ALERT_LEAD_CYC;

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_alert_lead;
		$rose(power.trx_en) |-> $past(radio_activity_alert, lead_cyc);
	endproperty
	a_alert_lead: assert property (p_alert_lead) else $error("transceiver on without alert lead");

	property p_alert_end;
		state == omb_pkg::omb_st_radio && radio_done && external_reset_pin_n |=> !radio_activity_alert && !power.trx_en;
	endproperty
	a_alert_end: assert property (p_alert_end) else $error("alert still high after event end");

	property p_reset_off;
		!external_reset_pin_n |=> power == '0 && state == omb_pkg::omb_st_reset;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("supplies not off in reset");

	property p_wake_active;
		state == omb_pkg::omb_st_reset ##1 external_reset_pin_n [*1] |-> ##[1:wake_lim] state == omb_pkg::omb_st_active
			or !external_reset_pin_n;
	endproperty
	a_wake_active: assert property (p_wake_active) else $error("activation did not reach active");

	property p_sleep_power;
		state == omb_pkg::omb_st_sleep |-> power.ls_osc_en && !power.hs_osc_en && !power.rf_if_en
			&& power.ram_retain && !power.debug_pwr;
	endproperty
	a_sleep_power: assert property (p_sleep_power) else $error("wrong power set in sleep");

	property p_wake_timer;
		state == omb_pkg::omb_st_sleep && ls_tick && wake_cnt == 16'h0000 && external_reset_pin_n
			|=> state == omb_pkg::omb_st_active && power.core_run;
	endproperty
	a_wake_timer: assert property (p_wake_timer) else $error("no wake on timer expiry");

	property p_radio_power;
		state == omb_pkg::omb_st_radio |-> power.trx_en && power.rf_if_en && power.hs_osc_en && power.core_run;
	endproperty
	a_radio_power: assert property (p_radio_power) else $error("radio mode power wrong");

	property p_boot_sample;
		$rose(boot_valid) |-> boot_from_rom == $past(boot_strap_input);
	endproperty
	a_boot_sample: assert property (p_boot_sample) else $error("boot strap not sampled");

	property p_sn_pad;
		sn_rd && sn_addr == `OMB_SN_ADDR_HI |=> sn_data[31:16] == `OMB_SN_PAD;
	endproperty
	a_sn_pad: assert property (p_sn_pad) else $error("serial number filler missing");

	property p_baud_min;
		$rose(baud_locked) |-> baud_div >= 16'(`OMB_MIN_BIT_CYC);
	endproperty
	a_baud_min: assert property (p_baud_min) else $error("baud lock below fastest bit time");

	property p_alert_idle;
		state inside {omb_pkg::omb_st_reset, omb_pkg::omb_st_wake, omb_pkg::omb_st_active, omb_pkg::omb_st_sleep}
			|-> !radio_activity_alert;
	endproperty
	a_alert_idle: assert property (p_alert_idle) else $error("alert high with no radio event");

	c_radio: cover property (state == omb_pkg::omb_st_radio ##[1:20] state == omb_pkg::omb_st_active);
	c_sleep_wake: cover property (state == omb_pkg::omb_st_sleep ##1 state == omb_pkg::omb_st_active);
	c_rom_boot: cover property ($rose(boot_valid) && boot_from_rom);
	c_baud: cover property ($rose(baud_locked));
endmodule : omb_top

/* File: sim/omb_board.sv */
// board-side model: reset pin, boot strap, loader serial line, shared gpio line
`timescale 1ns/1ps
module omb_board (
	input wire logic hold_reset,
	input wire logic want_rom,
	input wire logic line_low,
	output logic external_reset_pin_n,
	output logic boot_strap_input,
	output logic uart_rx_line,
	output logic shared_gpio_line
);
	// reset mode is entered by this pin going low or by sys_rst
	assign external_reset_pin_n = !hold_reset;
	// strap stays low unless a recovery boot is wanted, so power-up never lands in the loader
	assign boot_strap_input = want_rom;
	// idle high between characters; only the start bit pulls it low
	assign uart_rx_line = !line_low;
	// left as a pulled-down input while the alert pin is in use, so it reads low
	assign shared_gpio_line = 1'b0;
endmodule : omb_board

/* File: sim/test_omb_top.sv */
// self-checking testbench for the operating mode and boot control block
`timescale 1ns/1ps
module test_omb_top;
	logic clk, sys_rst, sleep_req, radio_done, sn_rd, hold_reset, want_rom, line_low;
	logic [15:0] wake_interval;
	logic [31:0] sn_addr;
	omb_pkg::omb_radio_req_type radio_req;
	omb_pkg::omb_power_type power;
	logic external_reset_pin_n, boot_strap_input, uart_rx_line, alert, rom, bvalid, locked;
	logic [31:0] sn_data;
	logic [15:0] baud_div;
	int error_cnt = 0;
	int total_checks = 0;
	localparam logic [47:0] SN = 48'hC0FFEE123456; // arbitrary value

	omb_board board_u (.hold_reset(hold_reset), .want_rom(want_rom), .line_low(line_low),
		.external_reset_pin_n(external_reset_pin_n), .boot_strap_input(boot_strap_input),
		.uart_rx_line(uart_rx_line), .shared_gpio_line());
	omb_top #(.SERIAL_ID(SN)) dut_u (.clk(clk), .sys_rst(sys_rst), .external_reset_pin_n(external_reset_pin_n),
		.boot_strap_input(boot_strap_input), .sleep_req(sleep_req), .wake_interval(wake_interval),
		.radio_req(radio_req), .radio_done(radio_done), .uart_rx_line(uart_rx_line), .sn_rd(sn_rd),
		.sn_addr(sn_addr), .power(power), .radio_activity_alert(alert), .boot_from_rom(rom),
		.boot_valid(bvalid), .sn_data(sn_data), .baud_div(baud_div), .baud_locked(locked));

	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// bounded wait for the core to run again
	task automatic wait_core(input int limit);
		int n;
		n = 0;
		while (power.core_run !== 1'b1 && n < limit) begin
			@(negedge clk);
			n++;
		end
		check("core_run", {31'h0, power.core_run}, 32'h1);
	endtask : wait_core

	task automatic check_active;
		check("active power", {23'h0, power.reg_en, power.hs_osc_en, power.rf_if_en, power.core_run,
			power.debug_pwr, power.trx_en, alert, 2'h0}, 32'h1F0);
	endtask : check_active

	task automatic test_power_up;
		check("power in reset", {23'h0, power}, 32'h0);
		check("alert in reset", {31'h0, alert}, 32'h0);
		@(negedge clk);
		sys_rst = 1'b0;
		wait_core(40);
		check_active();
		check("boot rom", {30'h0, rom, bvalid}, 32'h1);
	endtask : test_power_up

	task automatic test_radio(input logic is_tx);
		radio_req = is_tx ? 2'h2 : 2'h1;
		@(negedge clk);
		radio_req = 2'h0;
		check("alert lead", {31'h0, alert}, 32'h1);
		repeat (3) @(negedge clk);
		check("trx before lead", {31'h0, power.trx_en}, 32'h0);
		@(negedge clk);
		check("trx on", {30'h0, power.trx_en, power.trx_tx}, {30'h0, 1'b1, is_tx});
		check("core in radio", {31'h0, power.core_run}, 32'h1);
		repeat (5) @(negedge clk);
		check("alert held", {31'h0, alert}, 32'h1);
		radio_done = 1'b1;
		@(negedge clk);
		radio_done = 1'b0;
		check_active();
	endtask : test_radio

	task automatic test_sleep;
		// one count more than zero so the wake counter really has to step down
		wake_interval = 16'h0001;
		sleep_req = 1'b1;
		@(negedge clk);
		sleep_req = 1'b0;
		check("sleep power", {23'h0, power}, 32'h148);
		check("alert sleep", {31'h0, alert}, 32'h0);
		// no radio request is taken while asleep
		radio_req = 2'h2;
		repeat (6000) @(negedge clk);
		radio_req = 2'h0;
		check("still asleep", {31'h0, power.core_run}, 32'h0);
		check("no alert asleep", {31'h0, alert}, 32'h0);
		wait_core(200);
		check_active();
	endtask : test_sleep

	task automatic read_sn(input logic [31:0] addr, input logic [31:0] exp);
		sn_addr = addr;
		sn_rd = 1'b1;
		@(negedge clk);
		sn_rd = 1'b0;
		check("serial word", sn_data, exp);
		// strobe stays low for a full cycle between back-to-back reads
		@(negedge clk);
	endtask : read_sn

	task automatic test_ext_reset_rom;
		want_rom = 1'b1;
		hold_reset = 1'b1;
		repeat (2) @(negedge clk);
		check("power ext reset", {23'h0, power}, 32'h0);
		check("alert ext reset", {30'h0, alert, bvalid}, 32'h0);
		hold_reset = 1'b0;
		wait_core(40);
		check("boot rom", {30'h0, rom, bvalid}, 32'h3);
		want_rom = 1'b0;
	endtask : test_ext_reset_rom

	task automatic test_baud;
		// a low pulse shorter than one bit at the top rate is dropped
		line_low = 1'b1;
		repeat (100) @(negedge clk);
		line_low = 1'b0;
		repeat (3) @(negedge clk);
		check("short pulse", {31'h0, locked}, 32'h0);
		line_low = 1'b1;
		repeat (300) @(negedge clk);
		line_low = 1'b0;
		repeat (3) @(negedge clk);
		check("locked", {31'h0, locked}, 32'h1);
		check("div range", {31'h0, (baud_div >= 16'h012A && baud_div <= 16'h012E)}, 32'h1);
	endtask : test_baud

	initial begin
		sys_rst = 1'b1;
		sleep_req = 1'b0;
		radio_done = 1'b0;
		sn_rd = 1'b0;
		hold_reset = 1'b0;
		want_rom = 1'b0;
		line_low = 1'b0;
		wake_interval = 16'h0000;
		sn_addr = 32'h00000000;
		radio_req = 2'h0;
		repeat (20) @(negedge clk);
		test_power_up();
		test_radio(1'b1);
		test_radio(1'b0);
		test_sleep();
		read_sn(32'h100007F4, SN[31:0]);
		read_sn(32'h100007F8, {16'hAA55, SN[47:32]});
		read_sn(32'h100007FC, 32'h00000000);
		test_ext_reset_rom();
		test_baud();
		complete_run();
	end

	// the sequence needs about 7,000 cycles; 20,000 leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule : test_omb_top
